// File: ossd_pkg.sv
package ossd_pkg;
	// -------------------------------------------------------------
	// geometry and frame layout
	// -------------------------------------------------------------
	localparam int CH_COUNT = 8;
	localparam int PAR_COUNT = 4;
	localparam int FRAME_BITS = 16;
	localparam int CTRL_LSB = 8;
	localparam int DATA_LSB = 0;
	localparam logic [7:0] CMD_DIAG_ONLY = 8'h00;
	localparam logic [7:0] CMD_AND_DIAG = 8'hFF;
	localparam logic [7:0] SERIAL_RESET = 8'h00;

	// -------------------------------------------------------------
	// per-channel status codes, two bits each
	// -------------------------------------------------------------
	typedef logic [1:0] ossd_code_t;
	localparam ossd_code_t CODE_NORMAL = 2'h3;
	localparam ossd_code_t CODE_OVERLOAD = 2'h2;
	localparam ossd_code_t CODE_OPEN_LOAD = 2'h1;
	localparam ossd_code_t CODE_SHORT_GND = 2'h0;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int SYS_CLK_PS = 4000;
	localparam int TIMEBASE_NS = 1000;
	localparam int TB_CYCLES = TIMEBASE_NS * 1000 / SYS_CLK_PS;
	localparam int FAULT_DELAY_US = 100;
	localparam int FAULT_TICKS = FAULT_DELAY_US * 1000 / TIMEBASE_NS;
endpackage

// File: ossd_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two
// and three agree, so a single metastable sample cannot reach it
module ossd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_q;

	always_comb begin
		next_q = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & q_o);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end
endmodule

// File: ossd_fault_filter.sv
`timescale 1ns/1ps
// one channel's fault delay: a non-normal code must hold unchanged
// for more than TICKS timebase ticks before it counts as detected
module ossd_fault_filter
	import ossd_pkg::*;
#(
	parameter int TICKS = FAULT_TICKS,
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire ossd_pkg::ossd_code_t code_i,
	output ossd_pkg::ossd_code_t code_o,
	output logic qual_o,
	output logic qual_new_o
);
	logic [W-1:0] cnt, next_cnt;
	ossd_code_t next_code;
	logic next_qual, next_new;

	always_comb begin
		next_code = code_i;
		next_cnt = cnt;
		next_qual = qual_o;
		// any change or a return to normal restarts the delay
		if (code_i != code_o || code_i == CODE_NORMAL) begin
			next_cnt = '0;
			next_qual = 1'b0;
		end else if (!qual_o && tick_i) begin
			// exceed the delay strictly: one tick past the count
			if (cnt == W'(TICKS)) begin
				next_qual = 1'b1;
			end else begin
				next_cnt = cnt + W'(1);
			end
		end
		next_new = next_qual && !qual_o;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
			code_o <= CODE_NORMAL;
			qual_o <= 1'b0;
			qual_new_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			code_o <= next_code;
			qual_o <= next_qual;
			qual_new_o <= next_new;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	filter_delay_a: assert property (
		$rose(qual_o) |-> $past(cnt) == W'(TICKS) && $past(tick_i))
		else $error("fault qualified before the delay expired");
	filter_restart_a: assert property (
		code_i != code_o |=> cnt == '0 && !qual_o)
		else $error("fault delay not restarted on a changed condition");
endmodule

// File: ossd_top.sv
`timescale 1ns/1ps
// What this block does
// - control byte 00h: data byte ignored, outputs kept, status returned
// - diagnosis-only acts on its own frame; each frame decoded afresh
// - control byte FFh: load data bits, AND channels 1-4 with inputs
// - four per-channel conditions, each reported as a two-bit code
// - detected error is latched and pulls the fault flag low
// - fault flag is open-drain, active low, shared by all channels
// - error latched only after persisting longer than the fault delay
// - chip-select rise clears every error not newly detected that cycle; flag released if none remain
// - error still present after the clear is latched again
// - latched error stays readable until chip select rises
// - new error replaces old code; normal never replaces an error
// - chip-select falling edge copies latched status to the shifter
// - serial output undriven while chip select is high
// - channels 1-4 follow parallel inputs during diagnosis-only
// - codes: 11 normal, 10 overload, 01 open load, 00 short to ground
// - frame is a control byte then eight active-high channel bits
// - received bits reach the output latches only on chip-select rise
// - polarity select high: parallel inputs active high, else low
module ossd_top
	import ossd_pkg::*;
#(
	parameter int TB_DIV = TB_CYCLES,
	parameter int DELAY_TICKS = FAULT_TICKS
) (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic SI_I,
	output logic SO_O,
	output logic SO_OE_N_O,
	input wire logic FAULT_N_I,
	output logic FAULT_N_O,
	output logic FAULT_OE_N_O,
	input wire logic PARALLEL_POLARITY_SELECT_I,
	input wire logic [ossd_pkg::PAR_COUNT-1:0] PARALLEL_CHANNEL_INPUTS_I,
	input wire logic [ossd_pkg::CH_COUNT-1:0] OVERLOAD_CONDITION_I,
	input wire logic [ossd_pkg::CH_COUNT-1:0] SHORT_TO_BATTERY_CONDITION_I,
	input wire logic [ossd_pkg::CH_COUNT-1:0] OPEN_LOAD_CONDITION_I,
	input wire logic [ossd_pkg::CH_COUNT-1:0] SHORT_TO_GROUND_CONDITION_I,
	output logic [ossd_pkg::CH_COUNT-1:0] CHANNEL_ON_O
);
	localparam int DW = 2 * CH_COUNT;
	localparam logic [4:0] FRAME_LEN = 5'(FRAME_BITS);

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic any_err(input logic [DW-1:0] d);
		logic r;
		r = 1'b0;
		for (int i = 0; i < CH_COUNT; i++) begin
			r = r | (d[2*i +: 2] != CODE_NORMAL);
		end
		return r;
	endfunction

	// open load and short to ground show only when off, overload
	// only when on; an off channel with overload reads normal
	function automatic ossd_code_t raw_code(input logic on, input logic ov,
		input logic short_to_battery_condition, input logic ol, input logic short_to_ground_condition);
		ossd_code_t c;
		c = CODE_NORMAL;
		if (on && (ov || short_to_battery_condition)) begin
			c = CODE_OVERLOAD;
		end else if (!on && short_to_ground_condition) begin
			c = CODE_SHORT_GND;
		end else if (!on && ol) begin
			c = CODE_OPEN_LOAD;
		end
		return c;
	endfunction

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	logic [PAR_COUNT+1:0] ctl_q;
	logic [4*CH_COUNT-1:0] cond_q;
	logic cs_lvl, pol;
	logic [PAR_COUNT-1:0] par;

	ossd_sync #(.W(PAR_COUNT + 2), .RST_VAL(6'h30)) u_ctl_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESETN_I),
		.d_i({CS_N_I, PARALLEL_POLARITY_SELECT_I,
			PARALLEL_CHANNEL_INPUTS_I}),
		.q_o(ctl_q)
	);

	ossd_sync #(.W(4 * CH_COUNT), .RST_VAL('0)) u_cond_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESETN_I),
		.d_i({OVERLOAD_CONDITION_I, SHORT_TO_BATTERY_CONDITION_I,
			OPEN_LOAD_CONDITION_I, SHORT_TO_GROUND_CONDITION_I}),
		.q_o(cond_q)
	);

	assign cs_lvl = ctl_q[PAR_COUNT+1];
	assign pol = ctl_q[PAR_COUNT];
	assign par = ctl_q[PAR_COUNT-1:0];

	// -------------------------------------------------------------
	// link side: shift out on rising, sample on falling SCLK
	// -------------------------------------------------------------
	// chip select clears the frame counters directly, since the
	// link clock stands still outside frames
	logic [4:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
	logic next_so, next_so_oe_n;
	logic [FRAME_BITS-1:0] rx_data, next_rx_data;
	logic rx_done, next_rx_done;
	logic [DW-1:0] snap;

	always_comb begin
		next_tx_cnt = (tx_cnt == FRAME_LEN) ? tx_cnt : tx_cnt + 5'h01;
		next_so = 1'b0;
		if (tx_cnt < FRAME_LEN) begin
			next_so = snap[4'(FRAME_BITS - 1) - tx_cnt[3:0]];
		end
		next_so_oe_n = 1'b0;
		next_rx_cnt = (rx_cnt == FRAME_LEN) ? rx_cnt : rx_cnt + 5'h01;
		next_rx_data = rx_data;
		if (rx_cnt < FRAME_LEN) begin
			next_rx_data = {rx_data[FRAME_BITS-2:0], SI_I};
		end
		// only a frame of exactly sixteen bits is accepted
		next_rx_done = (rx_cnt == FRAME_LEN - 5'h01);
	end

	always_ff @(posedge SCLK_I or posedge CS_N_I) begin
		if (CS_N_I) begin
			tx_cnt <= '0;
			SO_O <= 1'b0;
			SO_OE_N_O <= 1'b1;
		end else begin
			tx_cnt <= next_tx_cnt;
			SO_O <= next_so;
			SO_OE_N_O <= next_so_oe_n;
		end
	end

	always_ff @(negedge SCLK_I or posedge CS_N_I) begin
		if (CS_N_I) begin
			rx_cnt <= '0;
		end else begin
			rx_cnt <= next_rx_cnt;
		end
	end

	always_ff @(negedge SCLK_I) begin
		rx_data <= next_rx_data;
	end

	always_ff @(negedge SCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_done <= 1'b0;
		end else begin
			rx_done <= next_rx_done;
		end
	end

	// -------------------------------------------------------------
	// fault detection and filtering
	// -------------------------------------------------------------
	logic [TB_DIV > 1 ? $clog2(TB_DIV) - 1 : 0:0] tb_cnt, next_tb_cnt;
	logic tick, next_tick;
	logic [DW-1:0] raw, fcode;
	logic [CH_COUNT-1:0] qual, qual_new;

	always_comb begin
		next_tick = (tb_cnt == $bits(tb_cnt)'(TB_DIV - 1));
		next_tb_cnt = next_tick ? '0 : tb_cnt + 1'b1;
		for (int i = 0; i < CH_COUNT; i++) begin
			raw[2*i +: 2] = raw_code(CHANNEL_ON_O[i],
				cond_q[3*CH_COUNT + i], cond_q[2*CH_COUNT + i],
				cond_q[CH_COUNT + i], cond_q[i]);
		end
	end

	for (genvar g = 0; g < CH_COUNT; g++) begin : g_filt
		ossd_fault_filter #(.TICKS(DELAY_TICKS), .W(8)) u_filt (
			.clk_i(SYS_CLK_I),
			.rst_n_i(RESETN_I),
			.tick_i(tick),
			.code_i(raw[2*g +: 2]),
			.code_o(fcode[2*g +: 2]),
			.qual_o(qual[g]),
			.qual_new_o(qual_new[g])
		);
	end

	// -------------------------------------------------------------
	// diagnosis register, snapshot and output control
	// -------------------------------------------------------------
	logic cs_prev, cs_rise, cs_fall;
	logic [7:0] serial, next_serial;
	logic [DW-1:0] diag, next_diag, next_snap;
	logic [CH_COUNT-1:0] next_on;
	logic [PAR_COUNT-1:0] par_act;
	logic next_fault_oe_n;

	assign cs_rise = cs_lvl && !cs_prev;
	assign cs_fall = !cs_lvl && cs_prev;
	assign par_act = par ^ {PAR_COUNT{!pol}};

	always_comb begin
		next_serial = serial;
		// 00h and unknown control bytes leave the latches alone
		if (cs_rise && rx_done &&
			rx_data[CTRL_LSB +: 8] == CMD_AND_DIAG) begin
			next_serial = rx_data[DATA_LSB +: 8];
		end
		// AND applies in every mode so PWM runs through diagnosis frames
		next_on = {serial[CH_COUNT-1:PAR_COUNT],
			serial[PAR_COUNT-1:0] & par_act};
		next_snap = cs_fall ? diag : snap;
		for (int i = 0; i < CH_COUNT; i++) begin
			next_diag[2*i +: 2] = diag[2*i +: 2];
			// a fresh detection beats the clear; a persisting one
			// relatches in the cycle after it
			if (qual_new[i]) begin
				next_diag[2*i +: 2] = fcode[2*i +: 2];
			end else if (cs_rise) begin
				next_diag[2*i +: 2] = CODE_NORMAL;
			end else if (qual[i]) begin
				next_diag[2*i +: 2] = fcode[2*i +: 2];
			end
		end
		next_fault_oe_n = !any_err(diag);
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			cs_prev <= 1'b1;
			serial <= SERIAL_RESET;
			CHANNEL_ON_O <= '0;
			snap <= {CH_COUNT{CODE_NORMAL}};
			diag <= {CH_COUNT{CODE_NORMAL}};
			FAULT_N_O <= 1'b1;
			FAULT_OE_N_O <= 1'b1;
			tb_cnt <= '0;
			tick <= 1'b0;
		end else begin
			cs_prev <= cs_lvl;
			serial <= next_serial;
			CHANNEL_ON_O <= next_on;
			snap <= next_snap;
			diag <= next_diag;
			FAULT_N_O <= next_fault_oe_n;
			FAULT_OE_N_O <= next_fault_oe_n;
			tb_cnt <= next_tb_cnt;
			tick <= next_tick;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);

	diag_only_keep_a: assert property (
		cs_rise && rx_done && rx_data[15:8] == CMD_DIAG_ONLY
		|=> serial == $past(serial))
		else $error("serial bits changed on a diagnosis-only frame");
	and_load_a: assert property (
		cs_rise && rx_done && rx_data[15:8] == CMD_AND_DIAG
		|=> serial == $past(rx_data[7:0]))
		else $error("data byte not loaded on an AND frame");
	latch_only_rise_a: assert property (
		!cs_rise |=> $stable(serial))
		else $error("output latches changed without chip-select rise");
	par_and_a: assert property (
		1'b1 |=> CHANNEL_ON_O[3:0] == ($past(serial[3:0]) & $past(par_act))
			&& CHANNEL_ON_O[7:4] == $past(serial[7:4]))
		else $error("channel outputs do not follow serial and inputs");
	fault_flag_a: assert property (
		any_err(diag) |=> !FAULT_OE_N_O && !FAULT_N_O)
		else $error("fault flag not asserted for a latched error");
	cs_clear_a: assert property (
		cs_rise && qual_new == '0 |=> !any_err(diag) ##1 FAULT_OE_N_O)
		else $error("chip-select rise did not clear the errors");
	relatch_a: assert property (
		cs_rise && qual != '0 ##1 qual != '0 |-> ##2 !FAULT_OE_N_O)
		else $error("persisting error not latched again after clear");
	err_hold_a: assert property (
		!cs_rise && qual == '0 |=> $stable(diag))
		else $error("latched status changed without cause");
	snap_a: assert property (
		cs_fall |=> snap == $past(diag))
		else $error("status not copied at chip-select fall");
	so_hiz_a: assert property (
		cs_lvl |-> SO_OE_N_O)
		else $error("serial output driven while chip select high");
endmodule

// File: ossd_spi_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// spi host model, link clock 12 ns
// ----------------------------------------
module ossd_spi_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_n_i,
	output logic [15:0] rx_o,
	output logic rx_v_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		si_o = 1'b1;
		rx_o = 16'h0000;
		rx_v_o = 1'b0;
		// a real rising edge presets the link flops, which have no reset
		#1 cs_n_o = 1'b1;
	end
	// sclk stands still between frames; idle si flips so no stale bit
	task automatic frame(input logic [15:0] tx);
		logic [15:0] rx;
		rx = 16'h0000;
		#1.7 cs_n_o = 1'b0;
		#40;
		for (int i = 15; i >= 0; i--) begin
			sclk_o = 1'b1;
			#3 si_o = tx[i];
			#3 sclk_o = 1'b0;
			// an undriven so reads as the inverse, never as a match
			rx[i] = so_oe_n_i ? ~so_i : so_i;
			#6;
		end
		cs_n_o = 1'b1;
		si_o = ~si_o;
		rx_o = rx;
		rx_v_o = 1'b1;
		#2 rx_v_o = 1'b0;
	endtask
endmodule

// File: ossd_top_tb.sv
`timescale 1ns/1ps
module ossd_top_tb;
	import ossd_pkg::*;
	logic clk, rst_n, pol, sclk, cs_n, si, so, so_oe_n, f_n, f_oe_n;
	logic [3:0] par;
	logic [7:0] ovl, short_to_battery_condition, ol, short_to_ground_condition, ch_on, ch_on_pin, rnd, old;
	logic [15:0] rx;
	logic rx_v, fault_wire, fault_pin, so_oe_n_s;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [15:0] exp_q[$];
	// open drain with pull-up
	assign fault_pin = f_oe_n ? 1'b1 : f_n;

	// outputs are looked at on the falling clock edge, once settled
	always @(negedge clk) begin
		ch_on <= ch_on_pin;
		fault_wire <= fault_pin;
		so_oe_n_s <= so_oe_n;
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	ossd_spi_host m (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so),
		.so_oe_n_i(so_oe_n), .rx_o(rx), .rx_v_o(rx_v));

	ossd_top #(.TB_DIV(2), .DELAY_TICKS(3)) dut (.SYS_CLK_I(clk),
		.RESETN_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
		.SO_O(so), .SO_OE_N_O(so_oe_n), .FAULT_N_I(fault_pin),
		.FAULT_N_O(f_n), .FAULT_OE_N_O(f_oe_n),
		.PARALLEL_POLARITY_SELECT_I(pol), .PARALLEL_CHANNEL_INPUTS_I(par),
		.OVERLOAD_CONDITION_I(ovl), .SHORT_TO_BATTERY_CONDITION_I(short_to_battery_condition),
		.OPEN_LOAD_CONDITION_I(ol), .SHORT_TO_GROUND_CONDITION_I(short_to_ground_condition),
		.CHANNEL_ON_O(ch_on_pin));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic send(input logic [15:0] w, input logic [15:0] e);
		exp_q.push_back(e);
		m.frame(w);
		cyc(12);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge rx_v) begin
		if (exp_q.size() == 0) begin
			failures++;
			$display("MISMATCH so word expected none seen %h", rx);
		end else begin
			check("so word", exp_q.pop_front(), rx);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		pol = 1'b1;
		par = 4'h0;
		{ovl, short_to_battery_condition, ol, short_to_ground_condition} = 32'h0000_0000;
		rnd = 8'h2B;
		cyc(8);
		rst_n <= 1'b1;
		cyc(1);
		check("ch on reset", 16'h0000, 16'(ch_on));
		check("so enable idle", 16'h0001, 16'(so_oe_n_s));
		// parallel inputs held active for serial control
		par <= 4'hF;
		rnd = lfsr(rnd);
		cyc(8);
		send({CMD_AND_DIAG, rnd}, 16'hFFFF);
		check("ch on serial", 16'(rnd), 16'(ch_on));
		par <= 4'h5;
		cyc(10);
		check("ch on and", 16'({rnd[7:4], rnd[3:0] & 4'h5}),
			16'(ch_on));
		pol <= 1'b0;
		par <= 4'hA;
		cyc(10);
		check("ch on pol", 16'({rnd[7:4], rnd[3:0] & 4'h5}),
			16'(ch_on));
		old = rnd;
		rnd = lfsr(rnd);
		send({CMD_DIAG_ONLY, rnd}, 16'hFFFF);
		check("ch on diag", 16'({old[7:4], old[3:0] & 4'h5}),
			16'(ch_on));
		par <= 4'h0;
		cyc(10);
		check("ch on pwm", 16'(old), 16'(ch_on));
		pol <= 1'b1;
		par <= 4'hF;
		cyc(8);
		send({CMD_AND_DIAG, 8'h0F}, 16'hFFFF);
		check("ch on next", 16'h000F, 16'(ch_on));
		// a spike shorter than the fault delay
		short_to_battery_condition <= 8'h02;
		cyc(5);
		short_to_battery_condition <= 8'h00;
		cyc(40);
		check("fault spike", 16'h0001, 16'(fault_wire));
		ovl <= 8'h01;
		ol <= 8'h30;
		cyc(60);
		check("fault low", 16'h0000, 16'(fault_wire));
		short_to_ground_condition <= 8'h20;
		cyc(60);
		ol <= 8'h00;
		short_to_ground_condition <= 8'h00;
		cyc(10);
		send({CMD_DIAG_ONLY, 8'h00}, 16'hF1FE);
		check("fault relatch", 16'h0000, 16'(fault_wire));
		send({CMD_DIAG_ONLY, 8'h00}, 16'hFFFE);
		ovl <= 8'h00;
		cyc(10);
		send({CMD_DIAG_ONLY, 8'h00}, 16'hFFFE);
		check("fault clear", 16'h0001, 16'(fault_wire));
		// a control byte that is neither command leaves the latches alone
		send({8'h3C, 8'hF0}, 16'hFFFF);
		check("ch on unknown", 16'h000F, 16'(ch_on));
		check("so words left", 16'h0000, 16'(exp_q.size()));
		summarize();
	end
endmodule
